// >>> bench/flash_power_mode_control_tb.sv
/* flash_power_mode_control_tb: scenario bench for fpm_top and a host model.
 * assumes fpm_checker is bound into fpm_top from its own file. */
`default_nettype none
module flash_power_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic hw_n = 1'b1;
	logic d3_n = 1'b1;
	logic busy = 1'b0;
	logic [7:0] sr = 8'h00;
	logic cs_n, sck, si, act, stb, slp, cen;
	logic [1:0] mode;
	int err_total = 0;
	int num_checks = 0;
	always #50 clock_i = ~clock_i;
	fpm_host h (.clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
	fpm_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .hw_reset_n_i(hw_n),
		.shared_data3_reset_pin_i(d3_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.volatile_status_one_i(sr), .busy_i(busy), .active_o(act), .standby_o(stb),
		.deep_sleep_state_o(slp), .cmd_enable_o(cen), .mode_o(mode));
	// compare one value and count it
	task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// print the counts and the verdict, then stop
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// busy keeps the device active after chip select rises
	task automatic t_busy();
		chk("mode", mode, fpm_pkg::ST_STANDBY);
		busy = 1'b1;
		h.frame(8'h05);
		chk("mode", mode, fpm_pkg::ST_ACTIVE);
		chk("active", {1'b0, act}, 2'h1);
		busy = 1'b0;
		h.step(10);
		chk("mode", mode, fpm_pkg::ST_STANDBY);
		chk("standby", {1'b0, stb}, 2'h1);
	endtask
	// sleep entry refused while a write is in progress; the write keeps it active
	task automatic t_wip();
		sr = 8'h01;
		h.frame(fpm_pkg::CMD_SLEEP_ENTER);
		chk("mode", mode, fpm_pkg::ST_ACTIVE);
		sr = 8'h00;
		h.step(fpm_pkg::ENTRY_CYC + 10);
		chk("mode", mode, fpm_pkg::ST_STANDBY);
	endtask
	// enter sleep; idle clock and other commands leave it asleep
	task automatic t_sleep();
		sr = 8'hfe; // only the write-in-progress bit may gate entry
		h.frame(fpm_pkg::CMD_SLEEP_ENTER);
		chk("mode", mode, fpm_pkg::ST_SLEEP);
		chk("sleep", {1'b0, slp}, 2'h1);
		sr = 8'h00;
		h.idle(20);
		h.frame(8'h06);
		h.frame(fpm_pkg::CMD_SLEEP_ENTER);
		chk("mode", mode, fpm_pkg::ST_SLEEP);
		chk("cmd_enable", {1'b0, cen}, 2'h0);
	endtask
	// release returns to standby only after the exit delay
	task automatic t_release();
		h.frame(fpm_pkg::CMD_SLEEP_RELEASE, 100);
		chk("mode", mode, fpm_pkg::ST_SLEEP);
		h.step(fpm_pkg::EXIT_CYC);
		chk("mode", mode, fpm_pkg::ST_STANDBY);
		chk("standby", {1'b0, stb}, 2'h1);
		chk("sleep", {1'b0, slp}, 2'h0);
	endtask
	// either reset pin wakes the device into standby
	task automatic t_hwrst();
		for (int k = 0; k < 2; k++) begin
			h.frame(fpm_pkg::CMD_SLEEP_ENTER);
			chk("mode", mode, fpm_pkg::ST_SLEEP);
			hw_n = (k != 0);
			d3_n = (k == 0);
			h.step(8);
			hw_n = 1'b1;
			d3_n = 1'b1;
			h.step(10);
			chk("mode", mode, fpm_pkg::ST_STANDBY);
			chk("cmd_enable", {1'b0, cen}, 2'h1);
		end
	endtask
	// main sequence
	initial begin
		h.step(20);
		resetn_i = 1'b1;
		h.step(5);
		t_busy();
		t_wip();
		t_sleep();
		t_release();
		t_hwrst();
		tally_and_finish();
	end
	// watchdog against a hang
	initial begin
		#3000000;
		err_total++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> bench/fpm_checker.sv
/* fpm_checker: timing assertions on the power-mode ports of fpm_top.
 * assumes one clock and the async active-low reset resetn_i. */
`default_nettype none
module fpm_checker (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hw_reset_n_i,
	input wire logic shared_data3_reset_pin_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic [7:0] volatile_status_one_i,
	input wire logic busy_i,
	input wire logic active_o,
	input wire logic standby_o,
	input wire logic deep_sleep_state_o,
	input wire logic cmd_enable_o,
	input wire logic [1:0] mode_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic ent;
	logic [8:0] hi_r, hi_nxt;
	assign ent = (mode_o == fpm_pkg::ST_ENTERING);
	// cycles since chip select last went high, saturating
	always_comb begin
		hi_nxt = (hi_r != 9'h1ff) ? hi_r + 9'h001 : hi_r;
		if (!cs_n_i)
			hi_nxt = 9'h000;
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			hi_r <= 9'h000;
		else
			hi_r <= hi_nxt;
	end
	// entering is held 28 cycles before sleep may begin
	sequence entry_hold_s;
		ent[*8] ##1 ent[*8] ##1 ent[*8] ##1 ent[*4];
	endsequence
	cs_active_a: assert property ((!cs_n_i && !deep_sleep_state_o)[*6] |-> active_o)
		else $error("chip select low but not active");
	busy_hold_a: assert property (active_o && busy_i |=> !standby_o)
		else $error("standby while busy");
	wip_block_a: assert property ($rose(ent) |-> !volatile_status_one_i[fpm_pkg::WIP_BIT])
		else $error("sleep entry while write in progress");
	cmd_gate_a: assert property (cmd_enable_o == !deep_sleep_state_o)
		else $error("command enable wrong in sleep");
	entry_delay_a: assert property ($rose(ent) |-> entry_hold_s ##[1:4] deep_sleep_state_o)
		else $error("entry delay wrong");
	sleep_via_a: assert property ($rose(deep_sleep_state_o) |-> $past(ent))
		else $error("sleep without entry");
	sleep_stay_a: assert property (deep_sleep_state_o && !cs_n_i |=> deep_sleep_state_o)
		else $error("woke while selected");
	exit_delay_a: assert property ($fell(deep_sleep_state_o) && hw_reset_n_i
		&& shared_data3_reset_pin_i |-> hi_r >= 9'h12b && hi_r <= 9'h136)
		else $error("exit delay wrong");
endmodule
bind fpm_top fpm_checker u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
	.hw_reset_n_i(hw_reset_n_i), .shared_data3_reset_pin_i(shared_data3_reset_pin_i),
	.cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .volatile_status_one_i(volatile_status_one_i),
	.busy_i(busy_i), .active_o(active_o), .standby_o(standby_o),
	.deep_sleep_state_o(deep_sleep_state_o), .cmd_enable_o(cmd_enable_o), .mode_o(mode_o));
`default_nettype wire

// >>> bench/fpm_host.sv
/* fpm_host: spi host model, mode 0, msb first, sck idle low.
 * assumes the bench clock; moves its pins 5 ns after a rising edge. */
`default_nettype none
module fpm_host (
	input wire logic clock_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	// wait n edges, then move off the edge
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#5;
	endtask
	// one command frame, then a quiet wait with chip select high
	task automatic frame(input logic [7:0] b, input int w = fpm_pkg::EXIT_CYC + 20);
		step(1);
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si_o = b[i];
			step(4);
			sck_o = 1'b1;
			step(4);
			sck_o = 1'b0;
		end
		step(4);
		cs_n_o = 1'b1;
		si_o = ~si_o; // released line shows no stale bit
		step(w);
	endtask
	// chip select low with the clock idle
	task automatic idle(input int n);
		step(1);
		cs_n_o = 1'b0;
		step(n);
		cs_n_o = 1'b1;
		step(fpm_pkg::EXIT_CYC + 20);
	endtask
endmodule
`default_nettype wire

// >>> src/fpm_cmd_if.sv
/*
 * fpm_cmd_if: carries decoded command bytes from the shifter to the mode fsm.
 * assumes one clock shared by both modules.
 */
`default_nettype none
interface fpm_cmd_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic frame_start;
	logic frame_end;
	logic sck_seen;
	modport src (output byte_valid, output byte_data, output frame_start,
		output frame_end, output sck_seen);
	modport dst (input byte_valid, input byte_data, input frame_start,
		input frame_end, input sck_seen);
endinterface
`default_nettype wire

// >>> src/fpm_pkg.sv
/*
 * fpm_pkg: constants shared by the flash power-mode control block.
 * assumes a 10 MHz system clock; serial inputs arrive asynchronously.
 */
`default_nettype none
package fpm_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	// command opcodes
	localparam logic [7:0] CMD_SLEEP_ENTER = 8'hb9;
	localparam logic [7:0] CMD_SLEEP_RELEASE = 8'hab;
	// status bit position of the write-in-progress flag
	localparam int unsigned WIP_BIT = 0;
	// delays in ns, longest-wait values rounded up to whole cycles
	localparam int unsigned ENTRY_DELAY_NS = 3000;
	localparam int unsigned EXIT_DELAY_NS = 30000;
	localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int unsigned ENTRY_CYC = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EXIT_CYC = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 12;
	localparam logic [2:0] BITS_LAST = 3'h7;
	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_ENTERING = 2'b10,
		ST_SLEEP = 2'b11
	} fpm_state_e;
endpackage
`default_nettype wire

// >>> src/fpm_shift.sv
/*
 * fpm_shift: synchronises chip select, serial clock and data in, and
 * shifts in the first byte of each frame (mode 0/3, msb first).
 * assumes the serial clock is far slower than the system clock.
 */
`default_nettype none
module fpm_shift (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	fpm_cmd_if.src cmd
);
	logic [2:0] cs_r, cs_nxt, sck_r, sck_nxt, si_r, si_nxt;
	logic cs_q_r, cs_q_nxt, sck_q_r, sck_q_nxt, si_q_r, si_q_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic got_r, got_nxt, seen_r, seen_nxt, vld_r, vld_nxt;
	logic rise;

	// three-stage synchronisers; a change counts once stages two and three agree
	always_comb begin
		cs_nxt = {cs_r[1:0], cs_n_i};
		sck_nxt = {sck_r[1:0], sck_i};
		si_nxt = {si_r[1:0], si_i};
		cs_q_nxt = (cs_r[1] == cs_r[2]) ? cs_r[2] : cs_q_r;
		sck_q_nxt = (sck_r[1] == sck_r[2]) ? sck_r[2] : sck_q_r;
		si_q_nxt = (si_r[1] == si_r[2]) ? si_r[2] : si_q_r;
	end

	assign rise = sck_q_nxt & ~sck_q_r;
	assign cmd.frame_start = cs_q_r & ~cs_q_nxt;
	assign cmd.frame_end = ~cs_q_r & cs_q_nxt;

	// bit counter and shifter, first byte per frame only
	always_comb begin
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		got_nxt = got_r;
		seen_nxt = seen_r;
		vld_nxt = 1'b0;
		if (cmd.frame_start) begin
			cnt_nxt = '0;
			got_nxt = 1'b0;
			seen_nxt = 1'b0;
		end else if (!cs_q_r && rise && !got_r) begin
			sh_nxt = {sh_r[6:0], si_q_nxt};
			cnt_nxt = cnt_r + 3'h1;
			seen_nxt = 1'b1;
			if (cnt_r == fpm_pkg::BITS_LAST) begin
				got_nxt = 1'b1;
				vld_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cs_r <= 3'h7;
			sck_r <= 3'h0;
			si_r <= 3'h0;
			cs_q_r <= 1'b1;
			sck_q_r <= 1'b0;
			si_q_r <= 1'b0;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			got_r <= 1'b0;
			seen_r <= 1'b0;
			vld_r <= 1'b0;
		end else begin
			cs_r <= cs_nxt;
			sck_r <= sck_nxt;
			si_r <= si_nxt;
			cs_q_r <= cs_q_nxt;
			sck_q_r <= sck_q_nxt;
			si_q_r <= si_q_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			got_r <= got_nxt;
			seen_r <= seen_nxt;
			vld_r <= vld_nxt;
		end
	end

	assign cmd.byte_valid = vld_r;
	assign cmd.byte_data = sh_r;
	assign cmd.sck_seen = seen_r;
endmodule
`default_nettype wire

// >>> src/fpm_top.sv
/*
 * fpm_top: power-mode control of a serial flash: active, standby,
 * sleep entry and deep sleep, driven by chip select and two commands.
 * assumes busy_i comes from the flash core on this clock; pins are async.
 */
// Operation
// R01: the device is active whenever chip select is low; the code stays in deep sleep while chip select is low.
// R02: after chip select rises the device stays active until no operation is pending.
// R03: byte b9 sent from standby is decoded as the sleep entry command.
// R04: sleep entry is accepted only while the write-in-progress flag is zero.
// R05: in deep sleep only the release command or a hardware reset has effect.
// R06: deep sleep begins once chip select is high and the entry delay has passed.
// R07: in deep sleep an idle clock or any other command leaves the device asleep.
// R08: release returns to standby after chip select rises and the exit delay passes.
// R09: the host must not toggle chip select without clock during release.
// R10: the host waits the full entry or release delay before any further command.
`default_nettype none
module fpm_top (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hw_reset_n_i,
	input wire logic shared_data3_reset_pin_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic [7:0] volatile_status_one_i,
	input wire logic busy_i,
	output logic active_o,
	output logic standby_o,
	output logic deep_sleep_state_o,
	output logic cmd_enable_o,
	output logic [1:0] mode_o
);
	fpm_cmd_if cmd ();
	fpm_pkg::fpm_state_e state_r, state_nxt;
	logic [fpm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic pend_r, pend_nxt;
	logic rel_r, rel_nxt;
	logic [2:0] hr_r, hr_nxt;
	logic hr_q_r, hr_q_nxt;
	logic write_in_progress_flag;
	logic cs_low_r, cs_low_nxt;

	fpm_shift u_shift (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.cs_n_i(cs_n_i),
		.sck_i(sck_i),
		.si_i(si_i),
		.cmd(cmd)
	);

	assign write_in_progress_flag = volatile_status_one_i[fpm_pkg::WIP_BIT];

	// hardware reset pins, both active low, through three stages
	always_comb begin
		hr_nxt = {hr_r[1:0], hw_reset_n_i & shared_data3_reset_pin_i};
		hr_q_nxt = (hr_r[1] == hr_r[2]) ? hr_r[2] : hr_q_r;
	end

	// mode state machine
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		pend_nxt = pend_r;
		rel_nxt = rel_r;
		cs_low_nxt = cs_low_r;
		if (cmd.frame_start) begin
			cs_low_nxt = 1'b1;
		end else if (cmd.frame_end) begin
			cs_low_nxt = 1'b0;
		end
		if (!hr_q_r) begin
			state_nxt = fpm_pkg::ST_STANDBY; // R05
			pend_nxt = 1'b0;
			rel_nxt = 1'b0;
			cnt_nxt = '0;
		end else begin
			unique case (state_r)
				fpm_pkg::ST_STANDBY, fpm_pkg::ST_ACTIVE: begin
					if (cmd.byte_valid && cmd.byte_data == fpm_pkg::CMD_SLEEP_ENTER
						&& !write_in_progress_flag && !busy_i) begin
						pend_nxt = 1'b1; // R03 R04
					end
					if (cs_low_nxt) begin
						state_nxt = fpm_pkg::ST_ACTIVE; // R01
					end else if (pend_r || pend_nxt) begin
						state_nxt = fpm_pkg::ST_ENTERING; // R06
						pend_nxt = 1'b0;
						cnt_nxt = fpm_pkg::CNT_W'(fpm_pkg::ENTRY_CYC);
					end else if (busy_i || write_in_progress_flag) begin
						state_nxt = fpm_pkg::ST_ACTIVE; // R02
					end else begin
						state_nxt = fpm_pkg::ST_STANDBY; // R02
					end
				end
				fpm_pkg::ST_ENTERING: begin
					if (cnt_r <= fpm_pkg::CNT_W'(1)) begin
						cnt_nxt = '0;
						state_nxt = fpm_pkg::ST_SLEEP; // R06
					end else begin
						cnt_nxt = cnt_r - fpm_pkg::CNT_W'(1);
					end
				end
				fpm_pkg::ST_SLEEP: begin
					if (rel_r) begin
						if (cnt_r != '0) begin
							cnt_nxt = cnt_r - fpm_pkg::CNT_W'(1);
							if (cnt_r == fpm_pkg::CNT_W'(1)) begin
								rel_nxt = 1'b0;
								state_nxt = fpm_pkg::ST_STANDBY; // R08
							end
						end else if (cmd.frame_end) begin
							cnt_nxt = fpm_pkg::CNT_W'(fpm_pkg::EXIT_CYC); // R08 R09
						end
					end else if (cmd.byte_valid
						&& cmd.byte_data == fpm_pkg::CMD_SLEEP_RELEASE) begin
						rel_nxt = 1'b1; // R05
					end
					// any other byte or an idle clock leaves the state as is
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= fpm_pkg::ST_STANDBY;
			cnt_r <= '0;
			pend_r <= 1'b0;
			rel_r <= 1'b0;
			hr_r <= 3'h7;
			hr_q_r <= 1'b1;
			cs_low_r <= 1'b0;
		end else begin
			state_r <= state_nxt; // R07
			cnt_r <= cnt_nxt;
			pend_r <= pend_nxt;
			rel_r <= rel_nxt;
			hr_r <= hr_nxt;
			hr_q_r <= hr_q_nxt;
			cs_low_r <= cs_low_nxt;
		end
	end

	// outputs from the state register
	assign active_o = (state_r == fpm_pkg::ST_ACTIVE) || (state_r == fpm_pkg::ST_ENTERING);
	assign standby_o = (state_r == fpm_pkg::ST_STANDBY);
	assign deep_sleep_state_o = (state_r == fpm_pkg::ST_SLEEP);
	assign cmd_enable_o = (state_r != fpm_pkg::ST_SLEEP); // R05
	assign mode_o = state_r;
endmodule
`default_nettype wire
